/* core/dcf_map.svh */
// constants for the dual clock fifo with mailbox ports
// assumes: included by the design files of the fifo block only
`ifndef DCF_MAP_SVH
`define DCF_MAP_SVH

`define DCF_WIDTH      36
`define DCF_DEPTH      64
`define DCF_PTR_W      7
`define DCF_THR_HH     7'h10
`define DCF_THR_HL     7'h0c
`define DCF_THR_LH     7'h08
`define DCF_THR_LL     7'h04
`define DCF_FULL_RST   1'b0
`define DCF_EMPTY_RST  1'b0
`define DCF_AE_RST     1'b0
`define DCF_AF_RST     1'b1
`define DCF_MBF_RST    1'b1

`endif

/* core/dcf_pkg.sv */
// types shared by the dual clock fifo with mailbox ports
// assumes: compiled before every module of the block
package dcf_pkg;

  // control pins of one port
  typedef struct packed {
    logic select_n;
    logic write_not_read;
    logic enable;
    logic mailbox_select;
  } dcf_port_ctl_s;

  // operation decoded at a port clock edge
  typedef enum logic [2:0] {
    DCF_OP_NONE,
    DCF_OP_FIFO_WR,
    DCF_OP_MAIL_WR,
    DCF_OP_FIFO_RD,
    DCF_OP_MAIL_RD
  } dcf_op_e;

  // enable and mailbox select decoding of one port
  function automatic dcf_op_e dcf_decode(input dcf_port_ctl_s c);
    dcf_op_e op;
    op = DCF_OP_NONE;
    if (!c.select_n && c.enable) begin
      if (c.write_not_read) begin
        op = c.mailbox_select ? DCF_OP_MAIL_WR : DCF_OP_FIFO_WR;
      end else begin
        op = c.mailbox_select ? DCF_OP_MAIL_RD : DCF_OP_FIFO_RD;
      end
    end
    return op;
  endfunction

endpackage

/* core/dcf_flag_pipe.sv */
// two stage status flag pipeline for one port of the fifo
// assumes: edge_pulse marks a port clock rising edge in the sys_clk domain
`timescale 1ns/1ps
`include "dcf_map.svh"

module dcf_flag_pipe #(
  parameter bit WRITE_SIDE = 1'b0
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic                  edge_pulse,
  input  wire logic                  hold_off,
  input  wire logic [`DCF_PTR_W-1:0] far_ptr,
  input  wire logic [`DCF_PTR_W-1:0] near_ptr,
  input  wire logic [`DCF_PTR_W-1:0] thresh,
  output logic                       flag_n,
  output logic                       almost_n
);

  logic [`DCF_PTR_W-1:0] far_s1;
  logic [`DCF_PTR_W-1:0] count;

  // fill level seen through the first stage
  assign count = WRITE_SIDE ? near_ptr - far_s1 : far_s1 - near_ptr;

  // first stage: sample the far pointer on the port edge
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      far_s1 <= '0;
    end else if (edge_pulse) begin
      far_s1 <= far_ptr;
    end
  end

  // second stage: flags from the sampled level
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flag_n   <= WRITE_SIDE ? `DCF_FULL_RST : `DCF_EMPTY_RST;
      almost_n <= WRITE_SIDE ? `DCF_AF_RST : `DCF_AE_RST;
    end else if (edge_pulse) begin
      if (WRITE_SIDE) begin
        flag_n   <= !hold_off && (count != 7'(`DCF_DEPTH));
        almost_n <= count < (7'(`DCF_DEPTH) - thresh);
      end else begin
        flag_n   <= count != 7'h00;
        almost_n <= count > thresh;
      end
    end
  end

endmodule // dcf_flag_pipe

/* core/dcf_fifo_mailbox.sv */
// 64 word by 36 bit fifo from port a to port b, with a mailbox each way
// assumes: port clocks arrive as inputs synchronous to sys_clk and are
// edge detected; the bus pins are resolved outside from the enables
//
// Operation
// - reset acts asynchronously to every clock
// - reset clears pointers, sets fifo flag levels
// - reset marks both mailboxes empty
// - full flag rises on second write edge
// - reset release loads threshold from selects
// - bus driven only when selected for read
// - write edge stores port a word
// - read edge loads fifo output register
// - port a shows second mailbox, read frees it
// - port b shows output or first mailbox
// - flags pass two stages in port domain
// - reads ignored while empty flag low
// - read pointer advances per output load
// - new word readable on third read cycle
// - empty rises second edge, read next cycle
// - late first edge delays synchronisation count
// - mailbox writes store the port bus
// - mailbox write marks occupied, blocks rewrites
// - writes ignored while full flag low
// - almost flags follow threshold fill levels
`timescale 1ns/1ps
`include "dcf_map.svh"

module dcf_fifo_mailbox (
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  input  wire logic                   write_port_clock,
  input  wire logic                   read_port_clock,
  input  wire logic                   threshold_select_lo,
  input  wire logic                   threshold_select_hi,
  input  wire dcf_pkg::dcf_port_ctl_s port_a_ctl,
  input  wire dcf_pkg::dcf_port_ctl_s port_b_ctl,
  input  wire logic [`DCF_WIDTH-1:0]  port_a_bus_in,
  output logic      [`DCF_WIDTH-1:0]  port_a_bus_out,
  output logic                        port_a_bus_oe,
  input  wire logic [`DCF_WIDTH-1:0]  port_b_bus_in,
  output logic      [`DCF_WIDTH-1:0]  port_b_bus_out,
  output logic                        port_b_bus_oe,
  output logic                        full_indicator_n,
  output logic                        empty_indicator_n,
  output logic                        almost_empty_n,
  output logic                        almost_full_n,
  output logic                        first_mailbox_occupied_n,
  output logic                        second_mailbox_occupied_n
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [`DCF_WIDTH-1:0] mem [`DCF_DEPTH];
  logic [`DCF_PTR_W-1:0] wptr;
  logic [`DCF_PTR_W-1:0] rptr;
  logic [`DCF_PTR_W-1:0] next_wptr;
  logic [`DCF_PTR_W-1:0] next_rptr;
  logic [`DCF_PTR_W-1:0] thresh;
  logic [`DCF_WIDTH-1:0] out_reg;
  logic [`DCF_WIDTH-1:0] first_mailbox;
  logic [`DCF_WIDTH-1:0] second_mailbox;
  logic                  wclk_q;
  logic                  rclk_q;
  logic                  wa_rise;
  logic                  rb_rise;
  logic                  thr_loaded;
  logic                  wa_started;
  logic                  fifo_wr;
  logic                  fifo_rd;
  logic                  first_mailbox_wr;
  logic                  first_mailbox_rd;
  logic                  second_mailbox_wr;
  logic                  second_mailbox_rd;
  dcf_pkg::dcf_op_e      op_a;
  dcf_pkg::dcf_op_e      op_b;

  // one step of a fifo pointer, wrapping past the full count
  function automatic logic [`DCF_PTR_W-1:0] ptr_step(input logic [`DCF_PTR_W-1:0] p);
    return p + 7'h01;
  endfunction

  // ****************************************************************
  // port clock edges and decoding
  // ****************************************************************

  // previous level of each port clock; kept running through reset so that a
  // clock already high at reset release is not taken for a fresh edge
  always_ff @(posedge sys_clk) begin
    wclk_q <= write_port_clock;
    rclk_q <= read_port_clock;
  end

  // rising edges and decoded port operations
  assign wa_rise  = write_port_clock && !wclk_q;
  assign rb_rise  = read_port_clock && !rclk_q;
  assign op_a     = dcf_pkg::dcf_decode(port_a_ctl);
  assign op_b     = dcf_pkg::dcf_decode(port_b_ctl);
  assign fifo_wr  = wa_rise && op_a == dcf_pkg::DCF_OP_FIFO_WR
                    && full_indicator_n;
  assign fifo_rd  = rb_rise && op_b == dcf_pkg::DCF_OP_FIFO_RD
                    && empty_indicator_n;
  assign first_mailbox_wr = wa_rise && op_a == dcf_pkg::DCF_OP_MAIL_WR
                    && first_mailbox_occupied_n;
  assign second_mailbox_wr = rb_rise && op_b == dcf_pkg::DCF_OP_MAIL_WR
                    && second_mailbox_occupied_n;
  assign first_mailbox_rd = rb_rise && op_b == dcf_pkg::DCF_OP_MAIL_RD;
  assign second_mailbox_rd = wa_rise && op_a == dcf_pkg::DCF_OP_MAIL_RD;
  assign next_wptr = fifo_wr ? ptr_step(wptr) : wptr;
  assign next_rptr = fifo_rd ? ptr_step(rptr) : rptr;

  // ****************************************************************
  // threshold and start up
  // ****************************************************************

  // threshold caught on the first clock after reset release
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      thr_loaded <= 1'b0;
      thresh     <= `DCF_THR_LL;
    end else if (!thr_loaded) begin
      thr_loaded <= 1'b1;
      unique case ({threshold_select_hi, threshold_select_lo})
        2'b11: thresh <= `DCF_THR_HH;
        2'b10: thresh <= `DCF_THR_HL;
        2'b01: thresh <= `DCF_THR_LH;
        2'b00: thresh <= `DCF_THR_LL;
      endcase
    end
  end

  // first write edge after reset keeps full low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wa_started <= 1'b0;
    end else if (wa_rise) begin
      wa_started <= 1'b1;
    end
  end

  // ****************************************************************
  // fifo storage and pointers
  // ****************************************************************

  // memory write, no reset needed on the array
  always_ff @(posedge sys_clk) begin
    if (fifo_wr) begin
      mem[wptr[5:0]] <= port_a_bus_in;
    end
  end

  // pointers cleared by reset, advanced by transfers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  // output register loads only on an accepted read
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      out_reg <= '0;
    end else if (fifo_rd) begin
      out_reg <= mem[rptr[5:0]];
    end
  end

  // ****************************************************************
  // status flags
  // ****************************************************************

  // full and almost full in the write port domain
  dcf_flag_pipe #(
    .WRITE_SIDE (1'b1)
  ) u_wflags (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .edge_pulse (wa_rise),
    .hold_off   (!wa_started),
    .far_ptr    (rptr),
    .near_ptr   (next_wptr),
    .thresh     (thresh),
    .flag_n     (full_indicator_n),
    .almost_n   (almost_full_n)
  );

  // empty and almost empty in the read port domain
  dcf_flag_pipe #(
    .WRITE_SIDE (1'b0)
  ) u_rflags (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .edge_pulse (rb_rise),
    .hold_off   (1'b0),
    .far_ptr    (wptr),
    .near_ptr   (next_rptr),
    .thresh     (thresh),
    .flag_n     (empty_indicator_n),
    .almost_n   (almost_empty_n)
  );

  // ****************************************************************
  // mailboxes
  // ****************************************************************

  // first mailbox: port a writes, port b reads
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      first_mailbox            <= '0;
      first_mailbox_occupied_n <= `DCF_MBF_RST;
    end else if (first_mailbox_wr) begin
      first_mailbox            <= port_a_bus_in;
      first_mailbox_occupied_n <= 1'b0;
    end else if (first_mailbox_rd) begin
      first_mailbox_occupied_n <= 1'b1;
    end
  end

  // second mailbox: port b writes, port a reads
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      second_mailbox            <= '0;
      second_mailbox_occupied_n <= `DCF_MBF_RST;
    end else if (second_mailbox_wr) begin
      second_mailbox            <= port_b_bus_in;
      second_mailbox_occupied_n <= 1'b0;
    end else if (second_mailbox_rd) begin
      second_mailbox_occupied_n <= 1'b1;
    end
  end

  // ****************************************************************
  // bus drive
  // ****************************************************************

  // enables follow the selects without a clock
  assign port_a_bus_oe  = !port_a_ctl.select_n && !port_a_ctl.write_not_read;
  assign port_b_bus_oe  = !port_b_ctl.select_n && !port_b_ctl.write_not_read;
  assign port_a_bus_out = second_mailbox;
  assign port_b_bus_out = port_b_ctl.mailbox_select ? first_mailbox : out_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [1:0] wa_edges;

  // write edges seen since reset, saturating
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wa_edges <= 2'h0;
    end else if (wa_rise && wa_edges != 2'h3) begin
      wa_edges <= wa_edges + 2'h1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // reset values of flags and mailbox markers
  chk_reset_flags: assert property ($rose(rstn) |-> !full_indicator_n
    && !empty_indicator_n && !almost_empty_n && almost_full_n && rptr == 7'h00)
    else $error("flags wrong after reset");
  chk_reset_mail: assert property ($rose(rstn) |-> first_mailbox_occupied_n
    && second_mailbox_occupied_n)
    else $error("mailbox flags wrong after reset");

  // write side start up, fifo writes and refusals
  chk_full_start: assert property (wa_edges < 2'h2 |-> !full_indicator_n)
    else $error("full flag rose before second write edge");
  chk_fifo_write: assert property (fifo_wr |=> wptr == $past(wptr) + 7'h01
    && mem[$past(wptr[5:0])] == $past(port_a_bus_in))
    else $error("fifo write not stored");
  chk_write_blocked: assert property (wa_rise && !full_indicator_n |=>
    wptr == $past(wptr))
    else $error("write taken while full");

  // read side loads and refusals
  chk_read_load: assert property (fifo_rd |=> rptr == $past(rptr) + 7'h01
    && out_reg == $past(mem[rptr[5:0]]))
    else $error("fifo read did not load output");
  chk_read_blocked: assert property (rb_rise && !empty_indicator_n |=>
    rptr == $past(rptr) && $stable(out_reg))
    else $error("read taken while empty");

  // bus sources while the outputs are active
  chk_bus_data: assert property (port_b_bus_oe && !port_b_ctl.mailbox_select
    |-> port_b_bus_out == out_reg)
    else $error("port b shows wrong source");

  // mailbox writes and reads, and empty flag held on a read edge while the fifo is empty
  chk_mail_block: assert property (wa_rise && !first_mailbox_occupied_n
    |=> $stable(first_mailbox))
    else $error("occupied mailbox overwritten");
  chk_mail_free: assert property (second_mailbox_rd && !second_mailbox_wr
    |=> second_mailbox_occupied_n)
    else $error("mailbox read did not free it");
  chk_empty_hold: assert property (rb_rise && wptr == rptr |=>
    !empty_indicator_n)
    else $error("empty flag rose too early");

  // threshold caught just after reset release: four words per select step
  chk_thresh_load: assert property ($rose(rstn) |=> thresh ==
    {3'h0, $past(threshold_select_hi), $past(threshold_select_lo), 2'h0} + 7'h04)
    else $error("threshold not loaded from selects");

  // flags move only on their own port edge
  chk_wflag_sync: assert property (!wa_rise |=> $stable(full_indicator_n)
    && $stable(almost_full_n))
    else $error("write flags moved off a write edge");
  chk_rflag_sync: assert property (!rb_rise |=> $stable(empty_indicator_n)
    && $stable(almost_empty_n))
    else $error("read flags moved off a read edge");

  // mailbox contents follow the bus on an accepted write and persist after a read
  chk_first_mailbox_store: assert property (first_mailbox_wr |=>
    first_mailbox == $past(port_a_bus_in) && !first_mailbox_occupied_n)
    else $error("first mailbox write not stored");
  chk_second_mailbox_store: assert property (second_mailbox_wr |=>
    second_mailbox == $past(port_b_bus_in) && !second_mailbox_occupied_n)
    else $error("second mailbox write not stored");
  chk_second_mailbox_block: assert property (rb_rise && !second_mailbox_occupied_n
    |=> $stable(second_mailbox))
    else $error("second mailbox overwritten while occupied");
  chk_first_mailbox_free: assert property (first_mailbox_rd && !first_mailbox_wr
    |=> first_mailbox_occupied_n && $stable(first_mailbox))
    else $error("first mailbox read did not free it");

  // port a always shows the second mailbox, port b the first one when selected
  chk_a_source: assert property (port_a_bus_oe
    |-> port_a_bus_out == second_mailbox)
    else $error("port a shows wrong source");
  chk_b_mail: assert property (port_b_bus_oe && port_b_ctl.mailbox_select
    |-> port_b_bus_out == first_mailbox)
    else $error("port b mailbox source wrong");

endmodule // dcf_fifo_mailbox

/* bench/dcf_port_host.sv */
// far side model of one fifo port: free running port clock and host bus
// assumes: ctl is driven by the bench; dev_out and dev_oe come from the fifo
`timescale 1ns/1ps

module dcf_port_host #(
  parameter int HALF = 2
) (
  input  wire logic                   sys_clk,
  input  wire dcf_pkg::dcf_port_ctl_s ctl,
  input  wire logic [35:0]            host_data,
  input  wire logic [35:0]            dev_out,
  input  wire logic                   dev_oe,
  output logic                        port_clk,
  output logic                        take,
  output logic [35:0]                 bus_in
);
  logic [3:0]  cnt = 4'h0;
  logic        clk_q = 1'b0;
  logic        clk_d = 1'b0;
  logic [35:0] last = 36'h0;

  // port clock divided from sys_clk; take marks the edge the fifo acts on
  always_ff @(posedge sys_clk) begin
    cnt   <= (cnt == 4'(HALF - 1)) ? 4'h0 : cnt + 4'h1;
    clk_q <= (cnt == 4'(HALF - 1)) ? ~clk_q : clk_q;
    clk_d <= clk_q;
  end
  assign port_clk = clk_q;
  assign take     = clk_q & ~clk_d;

  // host drives only for writes; a released wire shows the inverse of its last level
  assign bus_in = dev_oe ? dev_out
                : (!ctl.select_n && ctl.write_not_read) ? host_data : ~last;
  always_ff @(posedge sys_clk) last <= bus_in;
endmodule // dcf_port_host

/* bench/dcf_fifo_mailbox_tb.sv */
// self checking bench for the fifo with mailbox ports
// assumes: dcf_pkg, the fifo and the port host model are compiled first
`timescale 1ns/1ps

module dcf_fifo_mailbox_tb;
  // ****************************************
  // stimulus, model and checks
  // ****************************************
  localparam logic [3:0] IDLE = 4'h8, FWR = 4'h6, MWR = 4'h7, FRD = 4'h2, MRD = 4'h3;
  logic sys_clk = 1'b0, rstn = 1'b0, sel_hi = 1'b0, sel_lo = 1'b0;
  dcf_pkg::dcf_port_ctl_s ctl_a = IDLE, ctl_b = IDLE;
  logic [35:0] drv_a = 36'h0, drv_b = 36'h0, a_in, b_in, a_out, b_out, exp_w, last_w, wd;
  logic a_clk, b_clk, a_take, b_take, a_oe, b_oe, full_n, empty_n, ae_n, af_n;
  logic first_mailbox_occupied_n_n, second_mailbox_occupied_n_n;
  logic [35:0] q[$];
  int miscompares = 0, samples_checked = 0, cycles = 0, x;

  dcf_fifo_mailbox DUT (
    .sys_clk(sys_clk), .rstn(rstn), .write_port_clock(a_clk), .read_port_clock(b_clk),
    .threshold_select_lo(sel_lo), .threshold_select_hi(sel_hi), .port_a_ctl(ctl_a),
    .port_b_ctl(ctl_b), .port_a_bus_in(a_in), .port_a_bus_out(a_out), .port_a_bus_oe(a_oe),
    .port_b_bus_in(b_in), .port_b_bus_out(b_out), .port_b_bus_oe(b_oe),
    .full_indicator_n(full_n), .empty_indicator_n(empty_n), .almost_empty_n(ae_n),
    .almost_full_n(af_n), .first_mailbox_occupied_n(first_mailbox_occupied_n_n),
    .second_mailbox_occupied_n(second_mailbox_occupied_n_n));
  dcf_port_host #(.HALF(2)) host_a (.sys_clk(sys_clk), .ctl(ctl_a), .host_data(drv_a),
    .dev_out(a_out), .dev_oe(a_oe), .port_clk(a_clk), .take(a_take), .bus_in(a_in));
  dcf_port_host #(.HALF(3)) host_b (.sys_clk(sys_clk), .ctl(ctl_b), .host_data(drv_b),
    .dev_out(b_out), .dev_oe(b_oe), .port_clk(b_clk), .take(b_take), .bus_in(b_in));

  // system clock and hang guard
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic flag(input string nm, input logic e, input logic g);
    chk(nm, {35'h0, e}, {35'h0, g});
  endtask

  task automatic wait_a();
    do @(posedge sys_clk); while (!a_take);
  endtask

  task automatic wait_b();
    do @(posedge sys_clk); while (!b_take);
  endtask

  // one request per port edge; controls held until the edge that takes them
  task automatic op_a(input logic [3:0] c, input logic [35:0] d);
    @(posedge sys_clk);
    ctl_a <= c;
    drv_a <= d;
    wait_a();
    ctl_a <= IDLE;
  endtask

  task automatic op_b(input logic [3:0] c, input logic [35:0] d);
    @(posedge sys_clk);
    ctl_b <= c;
    drv_b <= d;
    wait_b();
    ctl_b <= IDLE;
  endtask

  // reset held over six read edges, which spans more than four of each clock
  task automatic do_reset(input logic [1:0] fs);
    @(posedge sys_clk);
    rstn <= 1'b0;
    {sel_hi, sel_lo} <= fs;
    repeat (6) wait_b();
    @(negedge sys_clk);
    flag("full_n", 1'b0, full_n);
    flag("empty_n", 1'b0, empty_n);
    flag("ae_n", 1'b0, ae_n);
    flag("af_n", 1'b1, af_n);
    flag("first_mailbox_occupied_n_n", 1'b1, first_mailbox_occupied_n_n);
    flag("second_mailbox_occupied_n_n", 1'b1, second_mailbox_occupied_n_n);
    @(posedge sys_clk);
    rstn <= 1'b1;
    wait_a();
    @(negedge sys_clk);
    flag("full_n", 1'b0, full_n);
    wait_a();
    @(negedge sys_clk);
    flag("full_n", 1'b1, full_n);
  endtask

  // compares each accepted fifo read with the oldest queued word
  always @(posedge sys_clk) begin
    if (b_take && ctl_b === FRD && empty_n === 1'b1) begin
      exp_w = q.pop_front();
      @(negedge sys_clk);
      chk("fifo_word", exp_w, b_out);
    end
  end

  // main sequence: fill and drain at every threshold, then mailboxes and tristate
  initial begin
    void'($urandom(99));
    for (int c = 0; c < 4; c++) begin
      x = 4 * (c + 1);
      do_reset(2'(c));
      for (int k = 1; k <= 65; k++) begin
        wd = 36'({$urandom(), $urandom()});
        if (k < 65) begin
          q.push_back(wd);
          last_w = wd;
        end
        op_a(FWR, wd);
        if (k == 1) begin
          wait_b();
          @(negedge sys_clk);
          flag("empty_n", 1'b0, empty_n);
          wait_b();
          @(negedge sys_clk);
          flag("empty_n", 1'b1, empty_n);
        end
        if (k == x || k == x + 1 || k == 63 - x || k == 64 - x || k == 64) begin
          repeat (40) @(posedge sys_clk);
          flag("ae_n", k > x, ae_n);
          flag("af_n", k < 64 - x, af_n);
          flag("full_n", k < 64, full_n);
        end
      end
      repeat (64) op_b(FRD, 36'h0);
      repeat (40) @(posedge sys_clk);
      flag("empty_n", 1'b0, empty_n);
      flag("ae_n", 1'b0, ae_n);
      flag("af_n", 1'b1, af_n);
      op_b(FRD, 36'h0);
      @(negedge sys_clk);
      chk("held_word", last_w, b_out);
      chk("words_left", 36'h0, 36'(q.size()));
    end
    wd = 36'({$urandom(), $urandom()});
    op_a(MWR, wd);
    @(negedge sys_clk);
    flag("first_mailbox_occupied_n_n", 1'b0, first_mailbox_occupied_n_n);
    op_a(MWR, ~wd);
    @(posedge sys_clk);
    ctl_b <= 4'h1;
    @(negedge sys_clk);
    flag("b_oe", 1'b1, b_oe);
    chk("first_mailbox", wd, b_out);
    op_b(MRD, 36'h0);
    @(negedge sys_clk);
    flag("first_mailbox_occupied_n_n", 1'b1, first_mailbox_occupied_n_n);
    op_b(MWR, ~wd);
    @(negedge sys_clk);
    flag("second_mailbox_occupied_n_n", 1'b0, second_mailbox_occupied_n_n);
    chk("second_mailbox", ~wd, a_out);
    op_a(MRD, 36'h0);
    @(negedge sys_clk);
    flag("second_mailbox_occupied_n_n", 1'b1, second_mailbox_occupied_n_n);
    chk("second_mailbox_kept", ~wd, a_out);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      ctl_a <= {i[1], i[0], 2'b00};
      ctl_b <= {i[1], i[0], 2'b00};
      @(negedge sys_clk);
      flag("a_oe", i == 0, a_oe);
      flag("b_oe", i == 0, b_oe);
    end
    finish_test();
  end
endmodule // dcf_fifo_mailbox_tb
